// File: design/mcu_map_regs.vh
// address map, register offsets, field positions and reset values
`ifndef MCU_MAP_REGS_VH
`define MCU_MAP_REGS_VH

// ----------------------------------------------------------------------
// address space
// ----------------------------------------------------------------------
`define MAP_ADDR_W 11
`define MAP_SPACE_BYTES 2048
`define MAP_IO_LAST 11'h01F
`define MAP_RAM_FIRST 11'h0C0
`define MAP_RAM_LAST 11'h0FF
`define MAP_ROM_FIRST 11'h300
`define MAP_ROM_LAST 11'h7CF
`define MAP_VEC_FIRST 11'h7F8
`define MAP_VEC_LAST 11'h7FF
`define MAP_WDOG_ADDR 11'h7F0

// ----------------------------------------------------------------------
// i/o register offsets
// ----------------------------------------------------------------------
`define REG_PORT_A_DATA 11'h000
`define REG_PORT_B_DATA 11'h001
`define REG_PORT_A_DIR 11'h004
`define REG_PORT_B_DIR 11'h005
`define REG_TIMER_SC 11'h008
`define REG_TIMER_COUNT 11'h009
`define REG_EXT_INT_SC 11'h00A
`define REG_PORT_A_PD 11'h010
`define REG_PORT_B_PD 11'h011

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define PORT_B_MASK 8'h3F
`define TSC_OVF_FLAG 7
`define TSC_RT_FLAG 6
`define TSC_RW_MASK 8'h33
`define TSC_OVF_RESET 3
`define TSC_RT_RESET 2
`define ISC_ENABLE 7
`define ISC_FLAG 3
`define ISC_FLAG_RESET 1
`define WDOG_CLEAR_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_SP 8'hFF
`define SP_FIXED_HIGH 8'hC0
`define READ_UNMAPPED 8'h00

`endif

// File: design/stack_ram.v
// 64 x 8 single port ram with registered read data
`default_nettype none

module stack_ram (
    input wire i_clk_sys,
    input wire i_we,
    input wire [5:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata
);

    reg [7:0] mem [0:63];

    // read-during-write returns the old byte
    always @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule // stack_ram

`default_nettype wire

// File: design/mcu_memory_map_decoder.v
// memory map decoder and i/o register bank of an 8-bit microcontroller
//
// Behaviour
// - internal clock is oscillator divided by two
// - low reset pin holds start-up state
// - decoder covers a 2 Kbyte address space
// - i/o registers accessed like ordinary memory
// - lowest 32 addresses are i/o section
// - watchdog clear decoded at 0x07F0
// - writing zero to bit 0 clears watchdog; reads rom
// - 64 ram bytes at 0x00C0-0x00FF, user and stack
// - interrupt entry saves five stack bytes
// - subroutine call pushes two return bytes
// - push post-decrements, pull pre-increments stack pointer
// - user rom 1232 bytes at 0x0300-0x07CF
// - vector rom at 0x07F8-0x07FF
// - reset and reset-sp instruction load 0x00FF
`include "mcu_map_regs.vh"
`default_nettype none

module mcu_memory_map_decoder (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_reset_pin_n,
    input wire [10:0] i_addr,
    input wire i_we,
    input wire i_re,
    input wire [7:0] i_wdata,
    input wire i_push,
    input wire i_pull,
    input wire i_reset_stack_pointer_instruction,
    input wire [7:0] i_rom_data,
    input wire [7:0] i_port_a_pins,
    input wire [5:0] i_port_b_pins,
    input wire [7:0] i_timer_count,
    input wire i_timer_ovf_flag,
    input wire i_timer_rt_flag,
    input wire i_ext_int_flag,
    output reg o_clk_op,
    output reg [7:0] o_rdata,
    output reg o_rvalid,
    output reg [7:0] o_sp,
    output reg [7:0] o_port_a_data,
    output reg [5:0] o_port_b_data,
    output reg [7:0] o_port_a_direction,
    output reg [5:0] o_port_b_direction,
    output reg [7:0] o_port_a_pulldown,
    output reg [5:0] o_port_b_pulldown,
    output reg [7:0] o_timer_control,
    output reg o_timer_ovf_reset,
    output reg o_timer_rt_reset,
    output reg o_ext_int_enable,
    output reg o_ext_int_flag_reset,
    output reg o_watchdog_clear
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function in_range;
        input [10:0] a;
        input [10:0] lo;
        input [10:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // ------------------------------------------------------------------
    // reset pin synchroniser and combined reset
    // ------------------------------------------------------------------
    reg rst_pin_meta_q;
    reg rst_pin_sync_q;
    wire rst;

    always @(posedge i_clk_sys) begin
        rst_pin_meta_q <= i_reset_pin_n;
        rst_pin_sync_q <= rst_pin_meta_q;
    end

    // pin low or synchronous reset both hold the start-up state
    assign rst = i_srst | ~rst_pin_sync_q;

    // ------------------------------------------------------------------
    // internal clock divider
    // ------------------------------------------------------------------
    // a divided output, not a second domain: everything here runs on
    // the oscillator edge so no crossing is needed
    always @(posedge i_clk_sys) begin
        if (rst) begin
            o_clk_op <= 1'b0;
        end else begin
            o_clk_op <= ~o_clk_op;
        end
    end

    // ------------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------------
    reg [7:0] pa_meta_q;
    reg [7:0] pa_sync_q;
    reg [5:0] pb_meta_q;
    reg [5:0] pb_sync_q;

    always @(posedge i_clk_sys) begin
        pa_meta_q <= i_port_a_pins;
        pa_sync_q <= pa_meta_q;
        pb_meta_q <= i_port_b_pins;
        pb_sync_q <= pb_meta_q;
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire sel_io;
    wire sel_ram;
    wire sel_rom;
    wire sel_vec;
    wire sel_wdog;
    wire stack_op;
    wire bus_wr;

    assign sel_io = in_range(i_addr, 11'h000, `MAP_IO_LAST);
    assign sel_ram = in_range(i_addr, `MAP_RAM_FIRST, `MAP_RAM_LAST);
    assign sel_rom = in_range(i_addr, `MAP_ROM_FIRST, `MAP_ROM_LAST);
    assign sel_vec = in_range(i_addr, `MAP_VEC_FIRST, `MAP_VEC_LAST);
    assign sel_wdog = (i_addr == `MAP_WDOG_ADDR);
    // a stack access owns the ram port; a bus access in that cycle is
    // dropped, the core never issues both at once
    assign stack_op = i_push | i_pull;
    assign bus_wr = i_we & ~stack_op;

    // ------------------------------------------------------------------
    // stack pointer
    // ------------------------------------------------------------------
    reg [7:0] sp_q;
    reg [7:0] sp_d;
    wire [7:0] sp_inc;
    wire [7:0] sp_dec;

    // upper bits stay fixed so the pointer wraps inside the stack ram
    assign sp_inc = `SP_FIXED_HIGH | ((sp_q + 8'h01) & 8'h3F);
    assign sp_dec = `SP_FIXED_HIGH | ((sp_q - 8'h01) & 8'h3F);

    always @* begin
        sp_d = sp_q;
        if (i_reset_stack_pointer_instruction) begin
            sp_d = `RST_SP;
        end else if (i_push) begin
            sp_d = sp_dec;
        end else if (i_pull) begin
            sp_d = sp_inc;
        end
    end

    always @(posedge i_clk_sys) begin
        if (rst) begin
            sp_q <= `RST_SP;
            o_sp <= `RST_SP;
        end else begin
            sp_q <= sp_d;
            o_sp <= sp_d;
        end
    end

    // ------------------------------------------------------------------
    // shared user and stack ram
    // ------------------------------------------------------------------
    reg [5:0] ram_addr;
    reg [7:0] ram_wdata;
    reg ram_we;
    wire [7:0] ram_rdata;

    // interrupt entry (five pushes) and call (two pushes) are byte
    // sequences issued by the core; each lands one byte here
    always @* begin
        ram_addr = i_addr[5:0];
        ram_wdata = i_wdata;
        ram_we = bus_wr & sel_ram;
        if (i_push) begin
            ram_addr = sp_q[5:0];
            ram_we = 1'b1;
        end else if (i_pull) begin
            ram_addr = sp_inc[5:0];
            ram_we = 1'b0;
        end
    end

    stack_ram u_stack_ram (
        .i_clk_sys(i_clk_sys),
        .i_we(ram_we),
        .i_addr(ram_addr),
        .i_wdata(ram_wdata),
        .o_rdata(ram_rdata)
    );

    // ------------------------------------------------------------------
    // i/o register writes
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (rst) begin
            o_port_a_data <= `RST_BYTE;
            o_port_b_data <= 6'h00;
            o_port_a_direction <= `RST_BYTE;
            o_port_b_direction <= 6'h00;
            o_port_a_pulldown <= `RST_BYTE;
            o_port_b_pulldown <= 6'h00;
            o_timer_control <= `RST_BYTE;
            o_ext_int_enable <= 1'b0;
            o_timer_ovf_reset <= 1'b0;
            o_timer_rt_reset <= 1'b0;
            o_ext_int_flag_reset <= 1'b0;
            o_watchdog_clear <= 1'b0;
        end else begin
            o_timer_ovf_reset <= 1'b0;
            o_timer_rt_reset <= 1'b0;
            o_ext_int_flag_reset <= 1'b0;
            o_watchdog_clear <= 1'b0;
            if (bus_wr && sel_io) begin
                case (i_addr)
                    `REG_PORT_A_DATA: begin
                        o_port_a_data <= i_wdata;
                    end
                    `REG_PORT_B_DATA: begin
                        o_port_b_data <= i_wdata[5:0];
                    end
                    `REG_PORT_A_DIR: begin
                        o_port_a_direction <= i_wdata;
                    end
                    `REG_PORT_B_DIR: begin
                        o_port_b_direction <= i_wdata[5:0];
                    end
                    `REG_TIMER_SC: begin
                        o_timer_control <= i_wdata & `TSC_RW_MASK;
                        o_timer_ovf_reset <= i_wdata[`TSC_OVF_RESET];
                        o_timer_rt_reset <= i_wdata[`TSC_RT_RESET];
                    end
                    `REG_EXT_INT_SC: begin
                        o_ext_int_enable <= i_wdata[`ISC_ENABLE];
                        o_ext_int_flag_reset <= i_wdata[`ISC_FLAG_RESET];
                    end
                    `REG_PORT_A_PD: begin
                        o_port_a_pulldown <= i_wdata;
                    end
                    `REG_PORT_B_PD: begin
                        o_port_b_pulldown <= i_wdata[5:0];
                    end
                    default: begin
                        // unused or read-only i/o slot (timer count): write dropped
                        o_watchdog_clear <= 1'b0;
                    end
                endcase
            end
            if (bus_wr && sel_wdog) begin
                // written zero on bit 0 services the watchdog
                o_watchdog_clear <= ~i_wdata[`WDOG_CLEAR_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // read path, stage one: i/o and rom data
    // ------------------------------------------------------------------
    reg [7:0] io_rdata;
    reg [7:0] rd_data_q;
    reg rd_ram_q;
    reg rd_valid_q;

    always @* begin
        case (i_addr)
            `REG_PORT_A_DATA: begin
                // input bits show the pin, output bits the latch
                io_rdata = (o_port_a_data & o_port_a_direction) |
                           (pa_sync_q & ~o_port_a_direction);
            end
            `REG_PORT_B_DATA: begin
                io_rdata = {2'b00, (o_port_b_data & o_port_b_direction) |
                           (pb_sync_q & ~o_port_b_direction)};
            end
            `REG_PORT_A_DIR: begin
                io_rdata = o_port_a_direction;
            end
            `REG_PORT_B_DIR: begin
                io_rdata = {2'b00, o_port_b_direction};
            end
            `REG_TIMER_SC: begin
                io_rdata = o_timer_control;
                io_rdata[`TSC_OVF_FLAG] = i_timer_ovf_flag;
                io_rdata[`TSC_RT_FLAG] = i_timer_rt_flag;
            end
            `REG_TIMER_COUNT: begin
                io_rdata = i_timer_count;
            end
            `REG_EXT_INT_SC: begin
                io_rdata = `READ_UNMAPPED;
                io_rdata[`ISC_ENABLE] = o_ext_int_enable;
                io_rdata[`ISC_FLAG] = i_ext_int_flag;
            end
            default: begin
                // pulldown registers are write-only and read zero
                io_rdata = `READ_UNMAPPED;
            end
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (rst) begin
            rd_data_q <= `READ_UNMAPPED;
            rd_ram_q <= 1'b0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_pull | (i_re & ~i_push);
            rd_ram_q <= i_pull | (i_re & ~i_push & sel_ram);
            if (sel_io) begin
                rd_data_q <= io_rdata;
            end else if (sel_rom || sel_vec || sel_wdog) begin
                rd_data_q <= i_rom_data;
            end else begin
                rd_data_q <= `READ_UNMAPPED;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path, stage two: output register
    // ------------------------------------------------------------------
    // two-stage read keeps the ram's registered output off a long mux
    always @(posedge i_clk_sys) begin
        if (rst) begin
            o_rdata <= `READ_UNMAPPED;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= rd_valid_q;
            o_rdata <= rd_ram_q ? ram_rdata : rd_data_q;
        end
    end

endmodule // mcu_memory_map_decoder

`default_nettype wire

// File: verification/mcu_map_props.sv
// concurrent checks on the memory map decoder ports
`default_nettype none
module mcu_map_props (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [10:0] i_addr,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [7:0] i_wdata,
    input wire logic i_push,
    input wire logic i_pull,
    input wire logic i_reset_stack_pointer_instruction,
    input wire logic [7:0] i_rom_data,
    input wire logic o_clk_op,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [7:0] o_sp,
    input wire logic o_watchdog_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    logic bus_only;
    assign bus_only = !i_push && !i_pull;
    sequence s_rd_taken;
        i_re && !i_we && bus_only;
    endsequence
    sequence s_answer;
        ##2 o_rvalid;
    endsequence
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_read_answer: assert property (s_rd_taken |-> s_answer)
        else $error("read not answered two cycles later");
    a_answer_cause: assert property (
        o_rvalid |-> $past(i_re || i_pull, 2))
        else $error("read data without a request");
    a_rom_data: assert property (s_rd_taken ##0
        (i_addr >= 11'h300 && i_addr <= 11'h7CF)
        |-> ##2 o_rdata == $past(i_rom_data, 2))
        else $error("rom read returned other data");
    a_unmapped_zero: assert property (s_rd_taken ##0
        (i_addr >= 11'h100 && i_addr <= 11'h2FF) |-> ##2 o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_wdog_pulse: assert property (i_we && bus_only &&
        i_addr == 11'h7F0 && !i_wdata[0] |=> ##[0:1] o_watchdog_clear)
        else $error("watchdog clear missing");
    a_wdog_cause: assert property (o_watchdog_clear |->
        $past(i_addr) == 11'h7F0 || $past(i_addr, 2) == 11'h7F0)
        else $error("watchdog clear from other address");
    a_wdog_data: assert property (o_watchdog_clear |->
        $past(i_we && !i_wdata[0] && i_addr == 11'h7F0))
        else $error("watchdog clear without a clearing write");
    a_sp_push: assert property (i_push |=> o_sp ==
        ($past(o_sp) == 8'hC0 ? 8'hFF : $past(o_sp) - 8'h01))
        else $error("push did not decrement stack pointer");
    a_sp_pull: assert property (i_pull && !i_push |=> o_sp ==
        ($past(o_sp) == 8'hFF ? 8'hC0 : $past(o_sp) + 8'h01))
        else $error("pull did not increment stack pointer");
    a_sp_reload: assert property (
        i_reset_stack_pointer_instruction && bus_only |=> o_sp == 8'hFF)
        else $error("stack pointer not reloaded");
    a_sp_window: assert property (o_sp[7:6] == 2'b11)
        else $error("stack pointer left the ram window");
    a_clk_halves: assert property (o_clk_op |=> !o_clk_op)
        else $error("op clock high two cycles");
endmodule // mcu_map_props
`default_nettype wire

// File: verification/cpu_side_model.sv
// far side model: program rom contents and port pins
`default_nettype none
module cpu_side_model (
    input wire logic [10:0] i_addr,
    input wire logic [7:0] i_port_a_data,
    input wire logic [5:0] i_port_b_data,
    output logic [7:0] o_rom_data,
    output logic [7:0] o_port_a_pins,
    output logic [5:0] o_port_b_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // address-dependent pattern so a wrong rom fetch shows
    assign o_rom_data = i_addr[7:0] ^ 8'h5A;
    // outside world drives the inverse of the latches, so an input bit
    // read back differs from what an output bit would show
    assign o_port_a_pins = ~i_port_a_data;
    assign o_port_b_pins = ~i_port_b_data;
endmodule // cpu_side_model
`default_nettype wire

// File: verification/test_mcu_memory_map_decoder.sv
// register-level testbench of the memory map decoder
`default_nettype none
module test_mcu_memory_map_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys, i_srst, i_reset_pin_n, i_we, i_re, i_push, i_pull;
    logic i_reset_stack_pointer_instruction, i_timer_ovf_flag;
    logic i_timer_rt_flag, i_ext_int_flag, o_clk_op, o_rvalid, c;
    logic o_watchdog_clear, o_timer_ovf_reset, o_timer_rt_reset;
    logic o_ext_int_enable, o_ext_int_flag_reset;
    logic [7:0] o_port_a_pulldown, o_timer_control;
    logic [10:0] i_addr;
    logic [7:0] i_wdata, i_rom_data, i_port_a_pins, i_timer_count;
    logic [7:0] o_rdata, o_sp, o_port_a_data, o_port_a_direction;
    logic [5:0] i_port_b_pins, o_port_b_data, o_port_b_direction;
    logic [5:0] o_port_b_pulldown;
    logic [10:0] holes [12] = '{11'h002, 11'h003, 11'h006, 11'h01F,
        11'h020, 11'h0BF, 11'h100, 11'h2FF, 11'h7D0, 11'h7EF, 11'h7F1,
        11'h7F7};
    logic [10:0] roms [5] = '{11'h300, 11'h7CF, 11'h7F0, 11'h7F8, 11'h7FF};
    int bad_count, comparisons;
    mcu_memory_map_decoder i_dut (.i_clk_sys, .i_srst, .i_reset_pin_n,
        .i_addr, .i_we, .i_re, .i_wdata, .i_push, .i_pull,
        .i_reset_stack_pointer_instruction, .i_rom_data, .i_port_a_pins,
        .i_port_b_pins, .i_timer_count, .i_timer_ovf_flag,
        .i_timer_rt_flag, .i_ext_int_flag, .o_clk_op, .o_rdata, .o_rvalid,
        .o_sp, .o_port_a_data, .o_port_b_data, .o_port_a_direction,
        .o_port_b_direction, .o_port_a_pulldown, .o_port_b_pulldown,
        .o_timer_control, .o_timer_ovf_reset, .o_timer_rt_reset,
        .o_ext_int_enable, .o_ext_int_flag_reset, .o_watchdog_clear);
    cpu_side_model i_far (.i_addr, .i_port_a_data(o_port_a_data),
        .i_port_b_data(o_port_b_data), .o_rom_data(i_rom_data),
        .o_port_a_pins(i_port_a_pins), .o_port_b_pins(i_port_b_pins));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_we <= 1'b1;
        @(posedge i_clk_sys);
        i_we <= 1'b0;
    endtask
    // bounded wait: a lost answer ends the run
    task automatic get(input logic [7:0] e);
        for (int n = 0; n < 6; n++) begin
            @(posedge i_clk_sys);
            #1;
            if (o_rvalid === 1'b1) begin
                chk("read data", e, o_rdata);
                return;
            end
        end
        bad_count++;
        give_verdict();
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_clk_sys);
        i_re <= 1'b0;
        get(e);
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wdata <= d;
        i_push <= 1'b1;
        @(posedge i_clk_sys);
        i_push <= 1'b0;
    endtask
    task automatic pull(input logic [7:0] e);
        @(posedge i_clk_sys);
        i_pull <= 1'b1;
        @(posedge i_clk_sys);
        i_pull <= 1'b0;
        get(e);
    endtask
    // write, then collect every reset pulse seen in the next three cycles
    task automatic wp(input logic [10:0] a, input logic [7:0] d,
        input logic [3:0] e);
        logic [3:0] seen;
        seen = 4'h0;
        wr(a, d);
        repeat (3) begin
            #1;
            seen = seen | {o_timer_ovf_reset, o_timer_rt_reset,
                o_ext_int_flag_reset, o_watchdog_clear};
            @(posedge i_clk_sys);
        end
        chk("reset pulses", {4'h0, e}, {4'h0, seen});
    endtask
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        {i_we, i_re, i_push, i_pull, i_reset_stack_pointer_instruction} = '0;
        {i_timer_ovf_flag, i_timer_rt_flag, i_ext_int_flag} = '0;
        i_addr = 11'h000;
        i_wdata = 8'h00;
        i_timer_count = 8'h00;
        i_reset_pin_n = 1'b1;
        i_srst = 1'b1;
        repeat (16) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        chk("stack pointer", 8'hFF, o_sp);
        c = o_clk_op;
        @(posedge i_clk_sys);
        #1;
        chk("op clock", {7'h00, ~c}, {7'h00, o_clk_op});
        rd(11'h004, 8'h00);
        wr(11'h004, 8'hA5);
        rd(11'h004, 8'hA5);
        chk("direction out", 8'hA5, o_port_a_direction);
        wr(11'h005, 8'hFF);
        rd(11'h005, 8'h3F);
        chk("direction b", 8'h3F, {2'b00, o_port_b_direction});
        wr(11'h004, 8'hFF);
        wr(11'h000, 8'h5A);
        rd(11'h000, 8'h5A);
        chk("port a out", 8'h5A, o_port_a_data);
        wr(11'h004, 8'hF0);
        rd(11'h000, 8'h55);
        wr(11'h001, 8'h2A);
        wr(11'h005, 8'h07);
        rd(11'h001, 8'h12);
        chk("port b out", 8'h2A, {2'b00, o_port_b_data});
        wr(11'h010, 8'hA5);
        wr(11'h011, 8'hFF);
        #1;
        chk("pulldown a", 8'hA5, o_port_a_pulldown);
        chk("pulldown b", 8'h3F, {2'b00, o_port_b_pulldown});
        rd(11'h010, 8'h00);
        rd(11'h011, 8'h00);
        foreach (holes[i]) begin
            wr(holes[i], 8'hFF);
            rd(holes[i], 8'h00);
        end
        wr(11'h0C0, 8'h3C);
        wr(11'h0FF, 8'hC3);
        rd(11'h0C0, 8'h3C);
        rd(11'h0FF, 8'hC3);
        foreach (roms[i]) begin
            rd(roms[i], roms[i][7:0] ^ 8'h5A);
        end
        @(posedge i_clk_sys);
        i_timer_count <= 8'h3C;
        {i_timer_ovf_flag, i_timer_rt_flag, i_ext_int_flag} <= 3'b111;
        rd(11'h009, 8'h3C);
        rd(11'h008, 8'hC0);
        rd(11'h00A, 8'h08);
        wp(11'h008, 8'hFF, 4'hC);
        chk("timer control", 8'h33, o_timer_control);
        rd(11'h008, 8'hF3);
        wp(11'h00A, 8'h82, 4'h2);
        chk("int enable", 8'h01, {7'h00, o_ext_int_enable});
        rd(11'h00A, 8'h88);
        wr(11'h009, 8'hFF);
        rd(11'h009, 8'h3C);
        wp(11'h7F0, 8'h00, 4'h1);
        wp(11'h7F0, 8'h01, 4'h0);
        for (int i = 0; i < 5; i++) push(8'h80 + 8'(i));
        #1;
        chk("stack pointer", 8'hFA, o_sp);
        push(8'h85);
        push(8'h86);
        #1;
        chk("stack pointer", 8'hF8, o_sp);
        for (int i = 6; i >= 0; i--) pull(8'h80 + 8'(i));
        pull(8'h3C);
        chk("stack pointer", 8'hC0, o_sp);
        @(posedge i_clk_sys);
        i_reset_stack_pointer_instruction <= 1'b1;
        @(posedge i_clk_sys);
        i_reset_stack_pointer_instruction <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        chk("stack pointer", 8'hFF, o_sp);
        push(8'h11);
        @(posedge i_clk_sys);
        i_reset_pin_n <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_reset_pin_n <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        rd(11'h004, 8'h00);
        chk("stack pointer", 8'hFF, o_sp);
        give_verdict();
    end
endmodule // test_mcu_memory_map_decoder
bind mcu_memory_map_decoder mcu_map_props i_props (.i_clk_sys, .i_srst,
    .i_addr, .i_we, .i_re, .i_wdata, .i_push, .i_pull,
    .i_reset_stack_pointer_instruction, .i_rom_data, .o_clk_op, .o_rdata,
    .o_rvalid, .o_sp, .o_watchdog_clear);
`default_nettype wire
